// >>> logic/bls_map.svh
// Register offsets, field positions, reset values and timing figures
`ifndef BLS_MAP_SVH
`define BLS_MAP_SVH

// Register offsets
`define BLS_OFS_SINK_SEL 8'h05
`define BLS_OFS_PWM_EN 8'h06
`define BLS_OFS_OFF_TOUT 8'h07
`define BLS_OFS_DIM_TOUT 8'h08
`define BLS_OFS_FADE 8'h09
`define BLS_OFS_CTRL 8'h0A
`define BLS_OFS_STATUS 8'h0B

// Reset value of every writable register
`define BLS_RST_REG 8'h00

// Field positions
`define BLS_SINK_MSB 6
`define BLS_TOUT_MSB 6
`define BLS_FADE_OUT_MSB 7
`define BLS_FADE_OUT_LSB 4
`define BLS_CTRL_GROUP_EN 0

// Timing figures: clock rate, seconds tick, full-scale fade per rate code
`define BLS_CLK_HZ 10000000
`define BLS_TICK_SEC 1
`define BLS_FADE_FS_MS 300
`define BLS_FADE_STEPS 127

// Serial slave address, value is arbitrary
`define BLS_I2C_ADDR 7'h2C

`endif

// >>> logic/bls_pkg.sv
// Types shared by the backlight control block
package bls_pkg;

    // Backlight timeout states, one-hot
    typedef enum logic [4:0] {
        BLS_ST_IDLE    = 5'h01,
        BLS_ST_RISE    = 5'h02,
        BLS_ST_DIMWAIT = 5'h04,
        BLS_ST_OFFWAIT = 5'h08,
        BLS_ST_OFF     = 5'h10
    } bls_light_state_type;

    // Serial slave states, one-hot
    typedef enum logic [4:0] {
        BLS_IS_IDLE  = 5'h01,
        BLS_IS_RX    = 5'h02,
        BLS_IS_ACK   = 5'h04,
        BLS_IS_TX    = 5'h08,
        BLS_IS_TXACK = 5'h10
    } bls_i2c_state_type;

    // Meaning of the byte being received
    typedef enum logic [1:0] {
        BLS_BYTE_ADDR = 2'h0,
        BLS_BYTE_REG  = 2'h1,
        BLS_BYTE_DATA = 2'h2
    } bls_byte_kind_type;

    // Whole state of the serial slave
    typedef struct packed {
        logic [2:0] scl_sync;
        logic [2:0] sda_sync;
        bls_i2c_state_type state;
        bls_byte_kind_type kind;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic [7:0] ptr;
        logic rw;
        logic acked;
        logic sda_oe;
        logic wr_stb;
        logic [7:0] wr_addr;
        logic [7:0] wr_data;
    } bls_i2c_regs_type;

    // Whole state of the backlight control
    typedef struct packed {
        logic [1:0] pwm_sync;
        logic [6:0] sink_sel;
        logic [6:0] pwm_en;
        logic [6:0] off_tout;
        logic [6:0] dim_tout;
        logic [7:0] fade;
        logic group_en;
        bls_light_state_type state;
        logic [6:0] level;
        logic [23:0] sec_cnt;
        logic [6:0] tout_cnt;
        logic [23:0] fade_cnt;
    } bls_ctl_regs_type;

endpackage

// >>> logic/bls_i2c_slave.sv
// Two-wire serial slave giving byte writes and reads with auto-increment
`timescale 1ns/1ps
`include "bls_map.svh"

module bls_i2c_slave #(
    parameter logic [6:0] DEV_ADDR = `BLS_I2C_ADDR
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Serial pins
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_oe,
    // Register side
    output logic o_wr_stb,
    output logic [7:0] o_wr_addr,
    output logic [7:0] o_wr_data,
    output logic [7:0] o_rd_addr,
    input wire logic [7:0] i_rdata
);

    bls_pkg::bls_i2c_regs_type cur_reg;
    bls_pkg::bls_i2c_regs_type cur_next;
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;

    // Line events, read only from the second and third sync stages
    assign scl_rise = cur_reg.scl_sync[1] & ~cur_reg.scl_sync[2];
    assign scl_fall = ~cur_reg.scl_sync[1] & cur_reg.scl_sync[2];
    assign start_c = cur_reg.scl_sync[1] & cur_reg.scl_sync[2] &
                     cur_reg.sda_sync[2] & ~cur_reg.sda_sync[1];
    assign stop_c = cur_reg.scl_sync[1] & cur_reg.scl_sync[2] &
                    ~cur_reg.sda_sync[2] & cur_reg.sda_sync[1];

    // Protocol sequencing
    always_comb begin
        cur_next = cur_reg;
        cur_next.wr_stb = 1'b0;
        cur_next.scl_sync = {cur_reg.scl_sync[1:0], i_scl};
        cur_next.sda_sync = {cur_reg.sda_sync[1:0], i_sda};
        if (stop_c) begin
            cur_next.state = bls_pkg::BLS_IS_IDLE;
            cur_next.sda_oe = 1'b0;
        end else if (start_c) begin
            cur_next.state = bls_pkg::BLS_IS_RX;
            cur_next.kind = bls_pkg::BLS_BYTE_ADDR;
            cur_next.bit_cnt = 4'h0;
            cur_next.sda_oe = 1'b0;
        end else begin
            case (cur_reg.state)
                bls_pkg::BLS_IS_RX: begin
                    if (scl_rise && cur_reg.bit_cnt != 4'h8) begin
                        cur_next.shreg = {cur_reg.shreg[6:0],
                                          cur_reg.sda_sync[1]};
                        cur_next.bit_cnt = cur_reg.bit_cnt + 4'h1;
                    end else if (scl_fall && cur_reg.bit_cnt == 4'h8) begin
                        cur_next.bit_cnt = 4'h0;
                        cur_next.state = bls_pkg::BLS_IS_ACK;
                        cur_next.sda_oe = 1'b1;
                        if (cur_reg.kind == bls_pkg::BLS_BYTE_ADDR) begin
                            cur_next.rw = cur_reg.shreg[0];
                            if (cur_reg.shreg[7:1] != DEV_ADDR) begin
                                cur_next.state = bls_pkg::BLS_IS_IDLE;
                                cur_next.sda_oe = 1'b0;
                            end
                        end else if (cur_reg.kind == bls_pkg::BLS_BYTE_REG) begin
                            cur_next.ptr = cur_reg.shreg;
                        end else begin
                            cur_next.wr_stb = 1'b1;
                            cur_next.wr_addr = cur_reg.ptr;
                            cur_next.wr_data = cur_reg.shreg;
                            cur_next.ptr = cur_reg.ptr + 8'h01;
                        end
                    end
                end
                bls_pkg::BLS_IS_ACK: begin
                    if (scl_fall) begin
                        cur_next.sda_oe = 1'b0;
                        if (cur_reg.kind == bls_pkg::BLS_BYTE_ADDR &&
                            cur_reg.rw) begin
                            cur_next.state = bls_pkg::BLS_IS_TX;
                            cur_next.shreg = i_rdata;
                            cur_next.sda_oe = ~i_rdata[7];
                        end else begin
                            cur_next.state = bls_pkg::BLS_IS_RX;
                            cur_next.kind =
                                (cur_reg.kind == bls_pkg::BLS_BYTE_ADDR) ?
                                bls_pkg::BLS_BYTE_REG : bls_pkg::BLS_BYTE_DATA;
                        end
                    end
                end
                bls_pkg::BLS_IS_TX: begin
                    if (scl_fall) begin
                        if (cur_reg.bit_cnt == 4'h7) begin
                            cur_next.sda_oe = 1'b0;
                            cur_next.state = bls_pkg::BLS_IS_TXACK;
                            cur_next.ptr = cur_reg.ptr + 8'h01;
                            cur_next.bit_cnt = 4'h0;
                        end else begin
                            cur_next.shreg = {cur_reg.shreg[6:0], 1'b0};
                            cur_next.sda_oe = ~cur_reg.shreg[6];
                            cur_next.bit_cnt = cur_reg.bit_cnt + 4'h1;
                        end
                    end
                end
                bls_pkg::BLS_IS_TXACK: begin
                    if (scl_rise) begin
                        cur_next.acked = ~cur_reg.sda_sync[1];
                    end else if (scl_fall) begin
                        if (cur_reg.acked) begin
                            cur_next.state = bls_pkg::BLS_IS_TX;
                            cur_next.shreg = i_rdata;
                            cur_next.sda_oe = ~i_rdata[7];
                        end else begin
                            cur_next.state = bls_pkg::BLS_IS_IDLE;
                        end
                    end
                end
                default: begin
                    cur_next.sda_oe = 1'b0;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur_reg <= '{scl_sync: 3'h7, sda_sync: 3'h7,
                         state: bls_pkg::BLS_IS_IDLE,
                         kind: bls_pkg::BLS_BYTE_ADDR, default: '0};
        end else begin
            cur_reg <= cur_next;
        end
    end

    // Outputs
    assign o_sda_oe = cur_reg.sda_oe;
    assign o_wr_stb = cur_reg.wr_stb;
    assign o_wr_addr = cur_reg.wr_addr;
    assign o_wr_data = cur_reg.wr_data;
    assign o_rd_addr = cur_reg.ptr;

endmodule // bls_i2c_slave

// >>> logic/bls_top.sv
// Backlight sink selection, PWM scaling and dim/off timeouts
`timescale 1ns/1ps
`include "bls_map.svh"

module bls_top #(
    parameter logic [6:0] DEV_ADDR = `BLS_I2C_ADDR,
    parameter int TICK_CYCLES = `BLS_TICK_SEC * `BLS_CLK_HZ,
    parameter int FADE_STEP_CYCLES =
        `BLS_FADE_FS_MS * (`BLS_CLK_HZ / 1000) / `BLS_FADE_STEPS
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Serial pins, data is open drain
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    // External PWM pin
    input wire logic i_pwm,
    // Per-sink enables of the independent controls
    input wire logic [6:0] i_sink_own_on,
    // Current codes from the current settings
    input wire logic [6:0] i_max_level,
    input wire logic [6:0] i_dim_level,
    // Sink controls
    output logic [6:0] o_sink_on,
    output logic [6:0] o_sink_pwm_scale,
    output logic [6:0] o_group_level
);

    localparam logic [23:0] TICK_LAST = 24'(TICK_CYCLES - 1);
    localparam logic [23:0] FADE_STEP = 24'(FADE_STEP_CYCLES);

    bls_pkg::bls_ctl_regs_type cur_reg;
    bls_pkg::bls_ctl_regs_type cur_next;
    logic wr_stb;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rdata;
    logic sec_tick;
    logic [23:0] fade_period;
    logic [3:0] fade_rate;
    logic [6:0] target;
    logic group_on;

    // Register read decode
    function automatic logic [7:0] read_reg(input logic [7:0] addr,
                                            input bls_pkg::bls_ctl_regs_type r);
        logic [7:0] v;
        v = 8'h00;
        if (addr == `BLS_OFS_SINK_SEL) begin
            v = {1'b0, r.sink_sel};
        end else if (addr == `BLS_OFS_PWM_EN) begin
            v = {1'b0, r.pwm_en};
        end else if (addr == `BLS_OFS_OFF_TOUT) begin
            v = {1'b0, r.off_tout};
        end else if (addr == `BLS_OFS_DIM_TOUT) begin
            v = {1'b0, r.dim_tout};
        end else if (addr == `BLS_OFS_FADE) begin
            v = r.fade;
        end else if (addr == `BLS_OFS_CTRL) begin
            v = {7'h00, r.group_en};
        end else if (addr == `BLS_OFS_STATUS) begin
            v = {3'h0, r.state};
        end
        return v;
    endfunction

    // Serial register port
    bls_i2c_slave #(
        .DEV_ADDR(DEV_ADDR)
    ) u_i2c (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_scl(i_scl),
        .i_sda(i_sda),
        .o_sda_oe(o_sda_oe),
        .o_wr_stb(wr_stb),
        .o_wr_addr(wr_addr),
        .o_wr_data(wr_data),
        .o_rd_addr(rd_addr),
        .i_rdata(rdata)
    );

    assign o_sda = 1'b0;
    assign rdata = read_reg(rd_addr, cur_reg);

    // Seconds tick and fade step period
    assign sec_tick = (cur_reg.sec_cnt >= TICK_LAST);
    assign fade_rate = cur_reg.fade[`BLS_FADE_OUT_MSB:`BLS_FADE_OUT_LSB];
    assign fade_period = 24'(fade_rate * FADE_STEP);
    assign group_on = (cur_reg.level != 7'h00);

    // Current the group heads for in each state
    always_comb begin
        case (cur_reg.state)
            bls_pkg::BLS_ST_RISE: target = i_max_level;
            bls_pkg::BLS_ST_DIMWAIT: target = i_max_level;
            bls_pkg::BLS_ST_OFFWAIT: begin
                target = (cur_reg.dim_tout != 7'h00) ?
                         i_dim_level : i_max_level;
            end
            default: target = 7'h00;
        endcase
    end

    // Register writes, timeout sequencing and level ramp
    always_comb begin
        cur_next = cur_reg;
        cur_next.pwm_sync = {cur_reg.pwm_sync[0], i_pwm};
        if (wr_stb) begin
            if (wr_addr == `BLS_OFS_SINK_SEL) begin
                cur_next.sink_sel = wr_data[`BLS_SINK_MSB:0];
            end else if (wr_addr == `BLS_OFS_PWM_EN) begin
                cur_next.pwm_en = wr_data[`BLS_SINK_MSB:0];
            end else if (wr_addr == `BLS_OFS_OFF_TOUT) begin
                cur_next.off_tout = wr_data[`BLS_TOUT_MSB:0];
            end else if (wr_addr == `BLS_OFS_DIM_TOUT) begin
                cur_next.dim_tout = wr_data[`BLS_TOUT_MSB:0];
            end else if (wr_addr == `BLS_OFS_FADE) begin
                cur_next.fade = wr_data;
            end else if (wr_addr == `BLS_OFS_CTRL) begin
                cur_next.group_en = wr_data[`BLS_CTRL_GROUP_EN];
            end
        end
        // Free-running seconds prescaler, restarted below per interval
        cur_next.sec_cnt = sec_tick ? 24'h0 : cur_reg.sec_cnt + 24'h1;
        case (cur_reg.state)
            bls_pkg::BLS_ST_IDLE: begin
                if (cur_reg.group_en) begin
                    cur_next.state = bls_pkg::BLS_ST_RISE;
                end
            end
            bls_pkg::BLS_ST_RISE: begin
                if (cur_reg.level == i_max_level) begin
                    if (cur_reg.dim_tout != 7'h00) begin
                        cur_next.state = bls_pkg::BLS_ST_DIMWAIT;
                        cur_next.tout_cnt = cur_reg.dim_tout;
                        cur_next.sec_cnt = 24'h0;
                    end else if (cur_reg.off_tout != 7'h00) begin
                        cur_next.state = bls_pkg::BLS_ST_OFFWAIT;
                        cur_next.tout_cnt = cur_reg.off_tout;
                        cur_next.sec_cnt = 24'h0;
                    end
                end
            end
            bls_pkg::BLS_ST_DIMWAIT: begin
                if (sec_tick) begin
                    if (cur_reg.tout_cnt <= 7'h01) begin
                        // Off count starts only now
                        cur_next.state = bls_pkg::BLS_ST_OFFWAIT;
                        cur_next.tout_cnt = cur_reg.off_tout;
                        cur_next.sec_cnt = 24'h0;
                    end else begin
                        cur_next.tout_cnt = cur_reg.tout_cnt - 7'h01;
                    end
                end
            end
            bls_pkg::BLS_ST_OFFWAIT: begin
                // A zero count holds dimmed: off timeout disabled
                if (sec_tick && cur_reg.tout_cnt != 7'h00) begin
                    if (cur_reg.tout_cnt == 7'h01) begin
                        cur_next.state = bls_pkg::BLS_ST_OFF;
                    end
                    cur_next.tout_cnt = cur_reg.tout_cnt - 7'h01;
                end
            end
            bls_pkg::BLS_ST_OFF: begin
                cur_next.state = bls_pkg::BLS_ST_OFF;
            end
            default: begin
                cur_next.state = bls_pkg::BLS_ST_IDLE;
            end
        endcase
        if (!cur_reg.group_en) begin
            cur_next.state = bls_pkg::BLS_ST_IDLE;
        end
        // Rising is immediate; falling fades at the programmed rate
        if (cur_reg.level <= target || fade_rate == 4'h0) begin
            cur_next.level = target;
            cur_next.fade_cnt = 24'h0;
        end else if (cur_reg.fade_cnt + 24'h1 >= fade_period) begin
            cur_next.level = cur_reg.level - 7'h01;
            cur_next.fade_cnt = 24'h0;
        end else begin
            cur_next.fade_cnt = cur_reg.fade_cnt + 24'h1;
        end
    end

    // State register
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cur_reg <= '{state: bls_pkg::BLS_ST_IDLE, default: '0};
        end else begin
            cur_reg <= cur_next;
        end
    end

    // Per-sink group selection and PWM scaling
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_sink
            assign o_sink_on[gi] = cur_reg.sink_sel[gi] ?
                                   i_sink_own_on[gi] :
                                   group_on;
            assign o_sink_pwm_scale[gi] = cur_reg.pwm_en[gi] ?
                                          cur_reg.pwm_sync[1] :
                                          1'b1;
        end
    endgenerate

    assign o_group_level = cur_reg.level;

    // Checks
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    sequence dim_expire_s;
        cur_reg.state == bls_pkg::BLS_ST_DIMWAIT && sec_tick &&
        cur_reg.tout_cnt == 7'h01 && cur_reg.group_en;
    endsequence

    sequence off_expire_s;
        cur_reg.state == bls_pkg::BLS_ST_OFFWAIT && sec_tick &&
        cur_reg.tout_cnt == 7'h01 && cur_reg.group_en;
    endsequence

    AST_SINK_INDEPENDENT: assert property (
        ((cur_reg.sink_sel & (o_sink_on ^ i_sink_own_on)) == 7'h00))
        else $error("independent sink not on its own enable");

    AST_SINK_GROUPED: assert property (
        ((~cur_reg.sink_sel & (o_sink_on ^ {7{o_group_level != 7'h00}}))
         == 7'h00))
        else $error("grouped sink does not follow group");

    AST_PWM_SCALED: assert property (
        (cur_reg.pwm_en & (o_sink_pwm_scale ^ {7{$past(i_pwm, 2)}}))
        == 7'h00)
        else $error("pwm enabled sink not scaled by pwm pin");

    AST_PWM_IGNORED: assert property (
        (~cur_reg.pwm_en & ~o_sink_pwm_scale) == 7'h00)
        else $error("pwm disabled sink responds to pwm");

    AST_OFF_EXPIRE: assert property (
        off_expire_s |=> cur_reg.state == bls_pkg::BLS_ST_OFF ##1
        (fade_rate != 4'h0 || o_group_level == 7'h00))
        else $error("off timeout did not turn backlight off");

    AST_OFF_AFTER_DIM: assert property (
        cur_reg.state == bls_pkg::BLS_ST_DIMWAIT |=>
        cur_reg.state != bls_pkg::BLS_ST_OFF)
        else $error("off reached while dim timeout counting");

    AST_OFF_ZERO_HOLD: assert property (
        cur_reg.state == bls_pkg::BLS_ST_OFFWAIT &&
        cur_reg.tout_cnt == 7'h00 && cur_reg.group_en |=>
        cur_reg.state == bls_pkg::BLS_ST_OFFWAIT)
        else $error("zero off timeout did not hold the backlight on");

    AST_GROUP_DISABLE: assert property (
        !cur_reg.group_en |=> cur_reg.state == bls_pkg::BLS_ST_IDLE)
        else $error("group did not drop to idle when disabled");

    AST_DIM_EXPIRE: assert property (
        dim_expire_s |=> cur_reg.state == bls_pkg::BLS_ST_OFFWAIT &&
        cur_reg.tout_cnt == cur_reg.off_tout && target == i_dim_level)
        else $error("dim timeout did not set dim level");

    AST_DIM_AT_MAX: assert property (
        cur_reg.state == bls_pkg::BLS_ST_RISE &&
        cur_reg.level != i_max_level |=>
        cur_reg.state != bls_pkg::BLS_ST_DIMWAIT)
        else $error("dim timeout started below maximum");

    AST_FADE_HOLD: assert property (
        fade_rate != 4'h0 && cur_reg.level > target &&
        cur_reg.fade_cnt == 24'h0 && $stable(fade_rate) |=>
        cur_reg.level == $past(cur_reg.level))
        else $error("fade dropped level without a step");

    AST_FADE_NONE: assert property (
        fade_rate == 4'h0 |=> o_group_level == $past(target))
        else $error("zero fade rate did not change at once");

    AST_TICK_RELOAD: assert property (
        cur_reg.state == bls_pkg::BLS_ST_RISE && cur_reg.group_en &&
        cur_next.state == bls_pkg::BLS_ST_DIMWAIT |=>
        cur_reg.tout_cnt == $past(cur_reg.dim_tout) &&
        cur_reg.sec_cnt == 24'h0)
        else $error("dim counter not reloaded at interval start");

endmodule // bls_top

// >>> tb/tb_bls_top.sv
// Self-checking bench for the backlight selection and timeout block
`timescale 1ns/1ps

module tb_bls_top;
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic scl = 1'b1;
    logic sda_drv = 1'b1;
    logic i_pwm = 1'b0;
    logic [6:0] i_sink_own_on = 7'h0F;
    logic [6:0] i_max_level = 7'h40;
    logic [6:0] i_dim_level = 7'h10;
    logic sda_oe;
    logic sda_out;
    logic [6:0] sink_on;
    logic [6:0] sink_scale;
    logic [6:0] level;
    // Open-drain line: the device pulls to its data value while enabled
    wire logic sda_line = sda_drv & (~sda_oe | sda_out);
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;

    bls_top #(.TICK_CYCLES(40), .FADE_STEP_CYCLES(3)) bls_top_inst (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda_line),
        .o_sda(sda_out), .o_sda_oe(sda_oe), .i_pwm(i_pwm),
        .i_sink_own_on(i_sink_own_on), .i_max_level(i_max_level),
        .i_dim_level(i_dim_level), .o_sink_on(sink_on),
        .o_sink_pwm_scale(sink_scale), .o_group_level(level));

    // Clock of 100 ns period
    always #50 i_mclk = ~i_mclk;

    // Verdict and end of run
    task automatic end_of_test();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Hang guard
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            n_mismatch = n_mismatch + 1;
            end_of_test();
        end
    end

    // Wait n edges, then step just past the edge
    task automatic wc(input int n);
        repeat (n) @(posedge i_mclk);
        #10;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons = comparisons + 1;
        if (got !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One byte MSB first, then the device acknowledge
    task automatic send_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda_drv = b[i];
            wc(10);
            scl = 1'b1;
            wc(10);
            scl = 1'b0;
        end
        sda_drv = 1'b1;
        wc(10);
        scl = 1'b1;
        wc(5);
        chk({7'h00, sda_line}, 8'h00);
        wc(5);
        scl = 1'b0;
    endtask

    // Register write: start, address, offset, data, stop
    task automatic reg_wr(input logic [7:0] ofs, input logic [7:0] d);
        wc(10);
        sda_drv = 1'b0;
        wc(10);
        scl = 1'b0;
        send_byte({7'h2C, 1'b0});
        send_byte(ofs);
        send_byte(d);
        sda_drv = 1'b0;
        wc(10);
        scl = 1'b1;
        wc(10);
        sda_drv = 1'b1;
        wc(5);
    endtask

    // Register read: offset write, repeated start, one byte, NACK, stop
    task automatic reg_rd(input logic [7:0] ofs, output logic [7:0] d);
        wc(10);
        sda_drv = 1'b0;
        wc(10);
        scl = 1'b0;
        send_byte({7'h2C, 1'b0});
        send_byte(ofs);
        wc(10);
        scl = 1'b1;
        wc(10);
        sda_drv = 1'b0;
        wc(10);
        scl = 1'b0;
        send_byte({7'h2C, 1'b1});
        for (int i = 7; i >= 0; i--) begin
            wc(10);
            scl = 1'b1;
            wc(5);
            d[i] = sda_line;
            wc(5);
            scl = 1'b0;
        end
        wc(10);
        scl = 1'b1;
        wc(10);
        scl = 1'b0;
        sda_drv = 1'b0;
        wc(10);
        scl = 1'b1;
        wc(10);
        sda_drv = 1'b1;
        wc(5);
    endtask

    // Bounded wait for the group level to reach full current
    task automatic wait_max();
        int k;
        k = 0;
        while (level !== i_max_level && k < 400) begin
            wc(1);
            k++;
        end
        chk({1'b0, level}, {1'b0, i_max_level});
    endtask

    // Selection and PWM enables with the group off
    task automatic t_select_pwm();
        logic [7:0] d;
        reg_wr(8'h05, 8'hD5);
        reg_wr(8'h06, 8'h2A);
        wc(2);
        chk({1'b0, sink_on}, 8'h05);
        reg_rd(8'h05, d);
        chk(d, 8'h55);
        reg_rd(8'h06, d);
        chk(d, 8'h2A);
        i_pwm = 1'b0;
        wc(4);
        chk({1'b0, sink_scale}, 8'h55);
        i_pwm = 1'b1;
        wc(4);
        chk({1'b0, sink_scale}, 8'h7F);
    endtask

    // Dim then off with immediate changes
    task automatic t_dim_off();
        logic [7:0] d;
        reg_wr(8'h08, 8'h02);
        reg_wr(8'h07, 8'h03);
        reg_wr(8'h0A, 8'h01);
        wait_max();
        chk({1'b0, sink_on}, 8'h2F);
        wc(20);
        chk({1'b0, level}, 8'h40);
        wc(40);
        chk({1'b0, level}, 8'h10);
        wc(80);
        chk({1'b0, level}, 8'h10);
        wc(40);
        chk({1'b0, level}, 8'h00);
        chk({1'b0, sink_on}, 8'h05);
        reg_rd(8'h0B, d);
        chk(d, 8'h10);
    endtask

    // Slow fade to dim, off timeout disabled
    task automatic t_fade();
        logic [7:0] d;
        reg_wr(8'h07, 8'h00);
        reg_wr(8'h09, 8'h10);
        reg_wr(8'h0A, 8'h00);
        reg_wr(8'h0A, 8'h01);
        wait_max();
        wc(100);
        chk({7'h00, level < 7'h40 && level > 7'h10}, 8'h01);
        wc(400);
        chk({1'b0, level}, 8'h10);
        reg_rd(8'h0B, d);
        chk(d, 8'h08);
    endtask

    // Main sequence
    initial begin
        wc(10);
        i_rst_n = 1'b1;
        wc(3);
        chk({1'b0, level}, 8'h00);
        t_select_pwm();
        t_dim_off();
        t_fade();
        end_of_test();
    end
endmodule // tb_bls_top
